/* pc_stack_defines.svh */
// Constants for the program counter and return stack
`ifndef PC_STACK_DEFINES_SVH
`define PC_STACK_DEFINES_SVH

`define PC_WIDTH        13
`define PC_LOW_WIDTH    8
`define PC_UPPER_WIDTH  5
`define LATCH_WIDTH     5
`define OPERAND_WIDTH   11
`define STACK_DEPTH     8
`define STACK_PTR_WIDTH 3
`define PC_RESET        13'h0000
`define LATCH_RESET     5'h00
`define PTR_RESET       3'h0

`endif

/* pc_stack_pkg.sv */
// Types used by the program counter; the return stack uses none of them
package pc_stack_pkg;

    typedef enum logic [4:0]
    {
        PC_HOLD   = 5'h01,
        PC_STEP   = 5'h02,
        PC_WRLOW  = 5'h04,
        PC_BRANCH = 5'h08,
        PC_RETURN = 5'h10
    } pc_action_type;

endpackage

/* return_stack.sv */
// Eight-entry circular return stack with a hidden pointer
`timescale 1ns/1ps
`default_nettype none

module return_stack
#(
    parameter int DEPTH = 8,
    parameter int WIDTH = 13,
    parameter int PTR_W = 3
)
(
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic             push_in,
    input  wire logic             pop_in,
    input  wire logic [WIDTH-1:0] push_data_in,
    output logic      [WIDTH-1:0] top_data_out
);

    typedef struct packed
    {
        logic [PTR_W-1:0] ptr;
    } stack_state_type;

    stack_state_type  state;
    stack_state_type  next_state;
    logic [WIDTH-1:0] entry [DEPTH];
    logic [PTR_W-1:0] top_index;

    // ****************************************************
    // Pointer
    // ****************************************************
    // Pointer is never exposed and wraps silently; no overflow flag
    always_comb
    begin
        next_state = state;
        if (push_in)
            next_state.ptr = state.ptr + PTR_W'(1); // see R13
        else if (pop_in)
            next_state.ptr = state.ptr - PTR_W'(1); // see R11
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            state <= '0;
        else
            state <= next_state;
    end

    assign top_index = state.ptr - PTR_W'(1);

    // ****************************************************
    // Storage
    // ****************************************************
    // Entries hold no reset: content after reset is never relied upon
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_entry
            always_ff @(posedge clk_in)
            begin
                if (push_in && state.ptr == PTR_W'(g))
                    entry[g] <= push_data_in; // see R08
            end
        end
    endgenerate

    always_comb
    begin
        top_data_out = entry[top_index];
    end

    a_ptr_push: assert property ( // see R13
        @(posedge clk_in) disable iff (!nrst_in)
        push_in |=> state.ptr == $past(state.ptr) + PTR_W'(1))
        else $error("Stack pointer did not advance on push");
    a_ptr_pop: assert property ( // see R11
        @(posedge clk_in) disable iff (!nrst_in)
        (pop_in && !push_in) |=> state.ptr == $past(state.ptr) - PTR_W'(1))
        else $error("Stack pointer did not retreat on pop");
    a_push_store: assert property ( // see R08
        @(posedge clk_in) disable iff (!nrst_in)
        push_in |=> entry[$past(state.ptr)] == $past(push_data_in))
        else $error("Pushed value was not stored");

endmodule

`default_nettype wire

/* program_counter.sv */
// Program counter with low-byte access, high latch and return stack
//
// How it works
// R01: Program counter is thirteen bits wide and addresses program memory.
// R02: Low eight bits are readable and writable by software.
// R03: Upper bits 12..8 load only from the high holding latch; here calls, jumps, returns, vectoring and stepping also change them.
// R04: Any reset clears the whole program counter.
// R05: Writing the low byte loads upper bits from latch bits 4..0.
// R06: Call or jump takes the top two bits from latch bits 4..3.
// R07: Software adding to the low byte must mind 256-word page crossings.
// R08: Return stack holds eight entries of thirteen bits.
// R09: Stack lies outside memory spaces; its pointer is not software visible.
// R10: Calls and interrupt vectoring push the program counter.
// R11: Return, return with literal and return from interrupt pop.
// R12: Push and pop leave the high holding latch unchanged.
// R13: Stack is a ring; the ninth push overwrites the first.
// R14: No overflow or underflow status exists.
// R15: Push stores the next address; pop loads all thirteen bits.
// R16: Call or jump: low eleven bits from operand, top two from latch.
`timescale 1ns/1ps
`default_nettype none
`include "pc_stack_defines.svh"

module program_counter
#(
    parameter int VECTOR = 13'h0004
)
(
    input  wire logic                          clk_in,
    input  wire logic                          nrst_in,
    input  wire logic                          step_in,
    input  wire logic                          low_write_in,
    input  wire logic [`PC_LOW_WIDTH-1:0]      low_data_in,
    input  wire logic                          latch_write_in,
    input  wire logic [`LATCH_WIDTH-1:0]       latch_data_in,
    input  wire logic                          jump_in,
    input  wire logic                          call_in,
    input  wire logic [`OPERAND_WIDTH-1:0]     operand_in,
    input  wire logic                          vector_in,
    input  wire logic                          return_in,
    input  wire logic                          return_with_literal_in,
    input  wire logic                          return_from_interrupt_in,
    output logic      [`PC_WIDTH-1:0]          pc_out,
    output logic      [`PC_LOW_WIDTH-1:0]      pc_low_byte_out,
    output logic      [`LATCH_WIDTH-1:0]       pc_high_latch_out
);

    // Counter and latch share one register, so a reset clears both at once
    typedef struct packed
    {
        logic [`PC_WIDTH-1:0]    pc;
        logic [`LATCH_WIDTH-1:0] pc_high_latch;
    } pc_state_type;

    pc_state_type                 state;
    pc_state_type                 next_state;
    pc_stack_pkg::pc_action_type  action;
    logic                         push;
    logic                         pop;
    logic [`PC_WIDTH-1:0]         pc_plus_one;
    logic [`PC_WIDTH-1:0]         stack_top;

    // ****************************************************
    // Decode
    // ****************************************************
    // Control flow wins over a low-byte write in the same cycle; decode
    // issues only one of them per instruction anyway
    assign push = call_in || vector_in; // see R10
    // All three return kinds pop alike; their other effects stay in the core
    assign pop  = return_in || return_with_literal_in
               || return_from_interrupt_in; // see R11
    // Stepping off the top of memory wraps to zero; nothing flags it
    assign pc_plus_one = state.pc + `PC_WIDTH'(1);

    always_comb
    begin
        if (pop)
            action = pc_stack_pkg::PC_RETURN;
        else if (push || jump_in)
            action = pc_stack_pkg::PC_BRANCH;
        else if (low_write_in)
            action = pc_stack_pkg::PC_WRLOW;
        else if (step_in)
            action = pc_stack_pkg::PC_STEP;
        else
            action = pc_stack_pkg::PC_HOLD;
    end

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb
    begin
        next_state = state;
        // Latch only changes by its own write, never by push or pop
        // A low write in the same cycle still sees the old latch value
        if (latch_write_in)
            next_state.pc_high_latch = latch_data_in; // see R12
        case (action)
            pc_stack_pkg::PC_STEP:
                next_state.pc = pc_plus_one;
            pc_stack_pkg::PC_WRLOW:
                // A computed jump wraps within its 256-word page
                next_state.pc = {state.pc_high_latch,
                                 low_data_in}; // see R05, R03, R07
            pc_stack_pkg::PC_BRANCH:
            begin
                // Vector alone: fixed address; with call or jump, operand
                if (vector_in && !call_in && !jump_in)
                    next_state.pc = `PC_WIDTH'(VECTOR);
                else
                    next_state.pc = {state.pc_high_latch[4:3],
                                     operand_in}; // see R06, R16
            end
            pc_stack_pkg::PC_RETURN:
                next_state.pc = stack_top; // see R15
            pc_stack_pkg::PC_HOLD:
                next_state.pc = state.pc;
            default:
                next_state.pc = state.pc;
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state.pc            <= `PC_RESET; // see R04
            state.pc_high_latch <= `LATCH_RESET;
        end
        else
            state <= next_state;
    end

    // ****************************************************
    // Return stack
    // ****************************************************
    // No pointer or overflow status leaves the stack
    // Wrap is silent: a ninth nested call loses the oldest return address
    return_stack
    #(
        .DEPTH (`STACK_DEPTH),
        .WIDTH (`PC_WIDTH),
        .PTR_W (`STACK_PTR_WIDTH)
    )
    u_stack
    (
        .clk_in       (clk_in),
        .nrst_in      (nrst_in),
        .push_in      (push && !pop),
        .pop_in       (pop && !push),
        .push_data_in (pc_plus_one), // see R15, R09, R14
        .top_data_out (stack_top)
    );

    // ****************************************************
    // Outputs
    // ****************************************************
    // Only registered values leave; the stack pointer stays hidden
    assign pc_out            = state.pc; // see R01
    assign pc_low_byte_out   = state.pc[`PC_LOW_WIDTH-1:0]; // see R02
    assign pc_high_latch_out = state.pc_high_latch;

    // ****************************************************
    // Checks
    // ****************************************************
    // Each check but a_reset_zero looks one edge after its cause and is abandoned by reset; a_reset_zero checks the same edge while reset is low
    a_low_write: assert property ( // see R05
        @(posedge clk_in) disable iff (!nrst_in)
        (action == pc_stack_pkg::PC_WRLOW)
        |=> pc_out == {$past(state.pc_high_latch), $past(low_data_in)})
        else $error("Low byte write did not load latch bits");
    a_branch_load: assert property ( // see R06
        @(posedge clk_in) disable iff (!nrst_in)
        (jump_in && !pop)
        |=> pc_out == {$past(state.pc_high_latch[4:3]), $past(operand_in)})
        else $error("Jump target wrong");
    a_call_load: assert property ( // see R16
        @(posedge clk_in) disable iff (!nrst_in)
        (call_in && !pop)
        |=> pc_out == {$past(state.pc_high_latch[4:3]), $past(operand_in)})
        else $error("Call target wrong");
    a_vector_load: assert property ( // see R10
        @(posedge clk_in) disable iff (!nrst_in)
        (vector_in && !call_in && !jump_in && !pop)
        |=> pc_out == `PC_WIDTH'(VECTOR))
        else $error("Vectoring did not reach the vector address");
    a_call_return: assert property ( // see R15
        @(posedge clk_in) disable iff (!nrst_in)
        (call_in && !pop) ##1 (return_in && !push && !low_write_in)
        |=> pc_out == $past(pc_out, 2) + `PC_WIDTH'(1))
        else $error("Return did not restore call address");
    a_pop_load: assert property ( // see R11
        @(posedge clk_in) disable iff (!nrst_in)
        pop |=> pc_out == $past(stack_top))
        else $error("Return did not load the stack top");
    a_latch_kept: assert property ( // see R12
        @(posedge clk_in) disable iff (!nrst_in)
        ((push || pop) && !latch_write_in) |=> $stable(state.pc_high_latch))
        else $error("Latch changed by push or pop");
    a_latch_write: assert property ( // see R05
        @(posedge clk_in) disable iff (!nrst_in)
        latch_write_in |=> pc_high_latch_out == $past(latch_data_in))
        else $error("Latch write was lost");
    a_hold_pc: assert property ( // see R03
        @(posedge clk_in) disable iff (!nrst_in)
        (action == pc_stack_pkg::PC_HOLD) |=> $stable(pc_out))
        else $error("Program counter moved without a cause");
    a_step_incr: assert property ( // see R01
        @(posedge clk_in) disable iff (!nrst_in)
        (action == pc_stack_pkg::PC_STEP) |=> pc_out == $past(pc_plus_one))
        else $error("Program counter did not step");
    a_reset_zero: assert property ( // see R04
        @(posedge clk_in)
        !nrst_in |-> pc_out == `PC_RESET)
        else $error("Program counter not cleared by reset");

    // ****************************************************
    // Coverage
    // ****************************************************
    c_call: cover property (@(posedge clk_in) disable iff (!nrst_in)
        call_in ##[1:20] return_in);
    c_vector: cover property (@(posedge clk_in) disable iff (!nrst_in)
        vector_in ##[1:20] return_from_interrupt_in);
    c_low_write: cover property (@(posedge clk_in) disable iff (!nrst_in)
        low_write_in);
    c_step_wrap: cover property (@(posedge clk_in) disable iff (!nrst_in)
        (action == pc_stack_pkg::PC_STEP) && (&state.pc));
    c_literal_return: cover property (@(posedge clk_in) disable iff (!nrst_in)
        return_with_literal_in ##1 return_from_interrupt_in);

endmodule

`default_nettype wire

/* pc_decode_model.sv */
// Decode stand-in that turns an operation code into pc controls
`timescale 1ns/1ps
`default_nettype none

module pc_decode_model
(
    input  wire logic [3:0]  op_in,
    input  wire logic [10:0] arg_in,
    input  wire logic [7:0]  pc_low_in,
    output logic             step_out,
    output logic             low_write_out,
    output logic      [7:0]  low_data_out,
    output logic             latch_write_out,
    output logic      [4:0]  latch_data_out,
    output logic             jump_out,
    output logic             call_out,
    output logic      [10:0] operand_out,
    output logic             vector_out,
    output logic             ret_out,
    output logic             ret_lit_out,
    output logic             ret_int_out
);
    // ****************
    // Decode
    // ****************
    assign step_out        = op_in == 4'h1;
    assign low_write_out   = op_in == 4'h2 || op_in == 4'ha;
    // Computed jump drops the carry, so it never leaves the page
    assign low_data_out    = (op_in == 4'ha) ? pc_low_in + arg_in[7:0]
                                              : arg_in[7:0];
    assign latch_write_out = op_in == 4'h3;
    assign latch_data_out  = arg_in[4:0];
    assign jump_out        = op_in == 4'h4;
    assign call_out        = op_in == 4'h5;
    assign operand_out     = arg_in;
    assign vector_out      = op_in == 4'h6;
    assign ret_out         = op_in == 4'h7;
    assign ret_lit_out     = op_in == 4'h8;
    assign ret_int_out     = op_in == 4'h9;
endmodule

`default_nettype wire

/* tb.sv */
// Self-checking bench for the program counter and return stack
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam logic [12:0] VEC_ADDR = 13'h0004;
    logic        clk_in = 1'b0;
    logic        nrst_in;
    logic [3:0]  op;
    logic [10:0] arg;
    logic        step, low_write, latch_write, jump, call, vector;
    logic        ret, ret_lit, ret_int;
    logic [7:0]  low_data, pc_low;
    logic [4:0]  latch_data, latch;
    logic [10:0] operand;
    logic [12:0] pc;
    logic [12:0] pushed [0:8];
    int          n_mismatch = 0;
    int          total_checks = 0;

    always #4 clk_in = ~clk_in;

    program_counter #(.VECTOR(VEC_ADDR)) dut_u (.clk_in(clk_in),
        .nrst_in(nrst_in), .step_in(step), .low_write_in(low_write),
        .low_data_in(low_data), .latch_write_in(latch_write),
        .latch_data_in(latch_data), .jump_in(jump), .call_in(call),
        .operand_in(operand), .vector_in(vector), .return_in(ret),
        .return_with_literal_in(ret_lit),
        .return_from_interrupt_in(ret_int), .pc_out(pc),
        .pc_low_byte_out(pc_low), .pc_high_latch_out(latch));

    pc_decode_model model_u (.op_in(op), .arg_in(arg), .pc_low_in(pc_low),
        .step_out(step), .low_write_out(low_write), .low_data_out(low_data),
        .latch_write_out(latch_write), .latch_data_out(latch_data),
        .jump_out(jump), .call_out(call), .operand_out(operand),
        .vector_out(vector), .ret_out(ret), .ret_lit_out(ret_lit),
        .ret_int_out(ret_int));

    // ****************
    // Tasks
    // ****************
    task automatic check(string name, logic [12:0] seen, logic [12:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic check_pc(logic [12:0] exp);
        check("pc", pc, exp);
        check("pc_low", {5'h00, pc_low}, {5'h00, exp[7:0]});
    endtask

    task automatic do_op(logic [3:0] code, logic [10:0] value);
        op = code;
        arg = value;
        @(negedge clk_in);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic t_low_write();
        do_op(4'h3, 11'h015);
        check_pc(13'h0000);
        do_op(4'h2, 11'h03c);
        check_pc(13'h153c);
        do_op(4'h0, 11'h000);
        check_pc(13'h153c);
        do_op(4'h3, 11'h01f);
        check_pc(13'h153c);
        do_op(4'h2, 11'h0ff);
        do_op(4'h1, 11'h000);
        check_pc(13'h0000);
    endtask

    task automatic t_call_return();
        do_op(4'h3, 11'h01a);
        do_op(4'h2, 11'h040);
        do_op(4'h5, 11'h123);
        check_pc(13'h1923);
        do_op(4'h7, 11'h000);
        check_pc(13'h1a41);
        check("latch", {8'h00, latch}, 13'h001a);
    endtask

    task automatic t_return_kinds();
        for (int k = 0; k < 3; k++)
        begin
            do_op(4'h4, 11'h0aa);
            do_op(4'h6, 11'h000);
            check_pc(VEC_ADDR);
            do_op(4'h5, 11'h200);
            do_op(4'(7 + k), 11'h000);
            check_pc(VEC_ADDR + 13'h0001);
            do_op(4'(7 + (k + 1) % 3), 11'h000);
            check_pc(13'h18ab);
        end
    endtask

    task automatic t_ring();
        do_op(4'h3, 11'h000);
        do_op(4'h4, 11'h100);
        for (int i = 0; i < 9; i++)
        begin
            pushed[i] = (i == 0) ? 13'h0101 : 13'(i + 1);
            do_op(4'h5, 11'(i + 1));
        end
        // Nine pops: the ring hands back the ninth push twice
        for (int j = 0; j < 9; j++)
        begin
            do_op(4'h7, 11'h000);
            check_pc(j < 8 ? pushed[8 - j] : pushed[8]);
        end
    endtask

    task automatic t_computed();
        do_op(4'h3, 11'h007);
        do_op(4'h2, 11'h0f0);
        do_op(4'ha, 11'h020);
        check_pc(13'h0710);
        do_op(4'h1, 11'h000);
        nrst_in = 1'b0;
        #1;
        check_pc(13'h0000);
        check("latch", {8'h00, latch}, 13'h0000);
        do_op(4'h0, 11'h000);
        nrst_in = 1'b1;
        do_op(4'h2, 11'h055);
        check_pc(13'h0055);
    endtask

    // ****************
    // Sequence
    // ****************
    initial
    begin
        repeat (5000) @(posedge clk_in);
        n_mismatch++;
        final_report();
    end

    initial
    begin
        nrst_in = 1'b1;
        op = 4'h0;
        arg = 11'h000;
        // A clean falling edge before the first clock, free of start-up races
        #1 nrst_in = 1'b0;
        repeat (3) @(negedge clk_in);
        check_pc(13'h0000);
        check("latch", {8'h00, latch}, 13'h0000);
        nrst_in = 1'b1;
        t_low_write();
        t_call_return();
        t_return_kinds();
        t_ring();
        t_computed();
        do_op(4'h0, 11'h000);
        final_report();
    end
endmodule

`default_nettype wire
